// ### bench/odc_host_model.sv
// Purpose: Host controller model that drives the configuration register port.
// Assumes: Requests are taken on the rising edge and a read answers one edge later.
// Notes:   Idle lines carry inverted last values, so a stale address never looks valid.
`timescale 1ns/10ps

module odc_host_model (
   input  wire logic             clock,
   input  wire logic [7:0]       cfg_rdata,
   input  wire logic             cfg_rvalid,
   output odc_pkg::odc_cfg_req_t cfg_req
);
   // Nothing is requested until the first task call.
   initial cfg_req = '0;

   // One write strobe, held for exactly one edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      cfg_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      cfg_req <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // One read strobe; the answer is awaited for a few edges only.
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int n;
      ok = 1'b0;
      d = 8'h00;
      @(posedge clock);
      cfg_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: ~a};
      @(posedge clock);
      cfg_req <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: a};
      for (n = 0; n < 4 && !ok; n++) begin
         #1;
         if (cfg_rvalid === 1'b1) begin
            d = cfg_rdata;
            ok = 1'b1;
         end else begin
            @(posedge clock);
         end
      end
   endtask
endmodule // odc_host_model

// ### bench/output_driver_control_regs_test.sv
// Purpose: Self-checking bench for the driver control register slice.
// Assumes: Outputs follow a write by two edges and the path inputs by one edge.
// Notes:   A byte array mirrors the registers and the expected outputs are decoded from it.
`timescale 1ns/10ps

module output_driver_control_regs_test;
   logic                     clock;
   logic                     reset;
   logic                     override;
   logic                     mute_state;
   logic [1:0]               psel;
   logic [1:0]               ssel;
   logic [7:0]               cfg_rdata;
   logic                     cfg_rvalid;
   logic [7:0]               d1;
   logic [7:0]               d2;
   odc_pkg::odc_cfg_req_t    cfg_req;
   odc_pkg::odc_driver_cfg_t driver_cfg;
   odc_pkg::odc_path_t       out_path;
   int                       n_fail;
   int                       checked;
   int                       seed;
   int                       i;
   int                       p;
   logic [7:0]               model [7];
   logic [7:0]               rst_tbl [7] = '{8'h0c, 8'h20, 8'ha3, 8'h69, 8'h3a, 8'h80, 8'hf2};

   odc_host_model host_u (.clock(clock), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
                          .cfg_req(cfg_req));

   output_driver_control_regs dut_u (.clock(clock), .reset(reset), .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .output_select_override(override),
      .primary_out_source_sel(psel), .secondary_out_source_sel(ssel),
      .mute_state(mute_state), .driver_cfg(driver_cfg), .out_path(out_path));

   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Expected driver settings; both upper common-mode codes give the highest level.
   function automatic logic [15:0] exp_drv();
      logic [7:0] c1;
      logic [7:0] c2;
      c1 = model[5];
      c2 = model[6];
      return {5'h00, (c1[7:6] == 2'h3) ? 2'h2 : c1[7:6], c1[4:0], c2[7:6], c2[5:4]};
   endfunction

   // Expected sources; mute wins over bypass and clock unless override is set.
   function automatic logic [15:0] exp_path();
      logic [1:0] pr;
      logic [1:0] se;
      pr = model[6][2] ? 2'h1 : 2'h0;
      se = model[6][0] ? 2'h2 : pr;
      if (override) begin
         pr = psel;
         se = ssel;
      end else if (!model[6][1]) begin
         pr = 2'h3;
         se = 2'h3;
      end
      return {11'h000, pr, se, mute_state};
   endfunction

   task automatic w(input logic [7:0] a, input logic [7:0] d);
      host_u.wr(a, d);
      if (a >= 8'h0c && a <= 8'h12)
         model[a - 8'h0c] = d;
   endtask

   // Unmapped addresses read as zero and still answer.
   task automatic rd_chk(input logic [7:0] a);
      logic [7:0] v;
      bit         ok;
      host_u.rd(a, v, ok);
      if (!ok) begin
         n_fail++;
         print_verdict();
      end
      check({8'h00, v}, {8'h00, (a >= 8'h0c && a <= 8'h12) ? model[a - 8'h0c] : 8'h00});
   endtask

   // A hang anywhere is cut short here.
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      print_verdict();
   end

   // Main sequence, run twice so the second reset lands after traffic.
   initial begin
      seed = 32'h57b6;
      n_fail = 0;
      checked = 0;
      reset = 1'b1;
      override = 1'b0;
      mute_state = 1'b0;
      psel = 2'h0;
      ssel = 2'h0;
      for (p = 0; p < 2; p++) begin
         @(posedge clock);
         reset <= 1'b1;
         repeat (20) @(posedge clock);
         reset <= 1'b0;
         override <= 1'b0;
         model = rst_tbl;
         @(posedge clock);
         #1;
         check({5'h00, driver_cfg}, exp_drv());
         check({11'h000, out_path}, exp_path());
         for (i = 8'h0b; i <= 8'h13; i++)
            rd_chk(i[7:0]);
         $display("test reset_values pass %0d done", p);
         for (i = 0; i < 32; i++) begin
            d1 = 8'($random(seed));
            d2 = 8'($random(seed));
            d1[7:6] = i[1:0];
            d1[5] = 1'b0;
            d2[3] = 1'b0;
            w(8'h11, d1);
            w(8'h12, d2);
            w((i[0]) ? 8'h13 : 8'h0b, d1);
            @(posedge clock);
            override <= i[3];
            psel <= i[1:0];
            ssel <= i[2:1];
            mute_state <= 1'($random(seed));
            @(posedge clock);
            #1;
            check({5'h00, driver_cfg}, exp_drv());
            check({11'h000, out_path}, exp_path());
            rd_chk(8'h11);
            rd_chk(8'h12);
         end
         $display("test random_fields pass %0d done", p);
         for (i = 0; i < 5; i++) begin
            w(8'h0c + i[7:0], rst_tbl[i]);
            rd_chk(8'h0c + i[7:0]);
         end
         $display("test reserved_rewrite pass %0d done", p);
      end
      print_verdict();
   end
endmodule // output_driver_control_regs_test

// ### core/odc_defs.svh
// Purpose: Offsets, field positions and reset values of the output driver control slice.
// Assumes: Byte-wide registers behind the serial configuration port.
// Notes:   Definitions only; included by the package and by the top module.
`ifndef ODC_DEFS_SVH
`define ODC_DEFS_SVH

// Register map.
`define ODC_REG_COUNT       7
`define ODC_FIRST_ADDR      8'h0c
`define ODC_ADDR_RSVD_A     8'h0c
`define ODC_ADDR_RSVD_B     8'h0d
`define ODC_ADDR_RSVD_C     8'h0e
`define ODC_ADDR_RSVD_D     8'h0f
`define ODC_ADDR_RSVD_E     8'h10
`define ODC_ADDR_CTRL1      8'h11
`define ODC_ADDR_CTRL2      8'h12
`define ODC_IDX_CTRL1       5
`define ODC_IDX_CTRL2       6
`define ODC_UNMAPPED_DATA   8'h00

// Reset values.
`define ODC_RST_RSVD_A      8'h0c
`define ODC_RST_RSVD_B      8'h20
`define ODC_RST_RSVD_C      8'ha3
`define ODC_RST_RSVD_D      8'h69
`define ODC_RST_RSVD_E      8'h3a
`define ODC_RST_CTRL1       8'h80
`define ODC_RST_CTRL2       8'hf2

// Driver level and power fields.
`define ODC_C1_VOS_HI       7
`define ODC_C1_VOS_LO       6
`define ODC_C1_PD_PRI       4
`define ODC_C1_PD_SEC       3
`define ODC_C1_EYE_SD       2
`define ODC_C1_EQ_BOOST     1
`define ODC_C1_INVERT       0

// Driver swing and path fields.
`define ODC_C2_SW_PRI_HI    7
`define ODC_C2_SW_PRI_LO    6
`define ODC_C2_SW_SEC_HI    5
`define ODC_C2_SW_SEC_LO    4
`define ODC_C2_BYPASS       2
`define ODC_C2_MUTE_N       1
`define ODC_C2_CLOCK_SEC    0

// Override source selection codes, two bits per output.
`define ODC_SEL_RECLOCKED   2'h0
`define ODC_SEL_BYPASSED    2'h1
`define ODC_SEL_CLOCK       2'h2
`define ODC_SEL_FORCED      2'h3

`endif

// ### core/odc_path_select.sv
// Purpose: Chooses what each serial output carries from register and override inputs.
// Assumes: Override field uses the codes in odc_defs.svh.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/10ps
`include "odc_defs.svh"

module odc_path_select (
   input  wire logic          override,
   input  wire logic [7:0]    path_reg,
   input  wire logic [1:0]    primary_sel,
   input  wire logic [1:0]    secondary_sel,
   input  wire logic          mute_state,
   output odc_pkg::odc_path_t path
);

   // Normal mode follows bypass, mute and clock bits; override ignores all three.
   always_comb begin
      path.forced_level = mute_state;
      if (override) begin
         path.primary_src   = odc_pkg::odc_sel_decode(primary_sel);
         path.secondary_src = odc_pkg::odc_sel_decode(secondary_sel);
      end else if (!path_reg[`ODC_C2_MUTE_N]) begin
         path.primary_src   = odc_pkg::ODC_SRC_FORCED;
         path.secondary_src = odc_pkg::ODC_SRC_FORCED;
      end else begin
         path.primary_src   = path_reg[`ODC_C2_BYPASS] ? odc_pkg::ODC_SRC_BYPASSED
                                                       : odc_pkg::ODC_SRC_RECLOCKED;
         if (path_reg[`ODC_C2_CLOCK_SEC]) begin
            path.secondary_src = odc_pkg::ODC_SRC_CLOCK;
         end else begin
            path.secondary_src = path.primary_src;
         end
      end
   end

endmodule // odc_path_select

// ### core/odc_pkg.sv
// Purpose: Types shared by the output driver control slice.
// Assumes: Constants come from odc_defs.svh.
// Notes:   Decode helpers live here so the top and its checks agree.
`include "odc_defs.svh"

package odc_pkg;

   typedef enum logic [1:0] {ODC_VOS_0P8, ODC_VOS_1P0, ODC_VOS_1P2} odc_vos_t;

   typedef enum logic [1:0] {
      ODC_SRC_RECLOCKED,
      ODC_SRC_BYPASSED,
      ODC_SRC_CLOCK,
      ODC_SRC_FORCED
   } odc_src_t;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } odc_cfg_req_t;

   typedef struct packed {
      odc_vos_t   common_mode;
      logic       primary_pd;
      logic       secondary_pd;
      logic       eye_sd;
      logic       eq_boost;
      logic       invert;
      logic [1:0] primary_swing;
      logic [1:0] secondary_swing;
   } odc_driver_cfg_t;

   typedef struct packed {
      odc_src_t primary_src;
      odc_src_t secondary_src;
      logic     forced_level;
   } odc_path_t;

   // Both codes above 01 give the highest level.
   function automatic odc_vos_t odc_vos_decode(input logic [1:0] code);
      case (code)
         2'h0:    odc_vos_decode = ODC_VOS_0P8;
         2'h1:    odc_vos_decode = ODC_VOS_1P0;
         default: odc_vos_decode = ODC_VOS_1P2;
      endcase
   endfunction

   function automatic odc_src_t odc_sel_decode(input logic [1:0] code);
      case (code)
         `ODC_SEL_RECLOCKED: odc_sel_decode = ODC_SRC_RECLOCKED;
         `ODC_SEL_BYPASSED:  odc_sel_decode = ODC_SRC_BYPASSED;
         `ODC_SEL_CLOCK:     odc_sel_decode = ODC_SRC_CLOCK;
         default:            odc_sel_decode = ODC_SRC_FORCED;
      endcase
   endfunction

   function automatic logic [7:0] odc_reset_value(input int idx);
      case (idx)
         0:       odc_reset_value = `ODC_RST_RSVD_A;
         1:       odc_reset_value = `ODC_RST_RSVD_B;
         2:       odc_reset_value = `ODC_RST_RSVD_C;
         3:       odc_reset_value = `ODC_RST_RSVD_D;
         4:       odc_reset_value = `ODC_RST_RSVD_E;
         5:       odc_reset_value = `ODC_RST_CTRL1;
         default: odc_reset_value = `ODC_RST_CTRL2;
      endcase
   endfunction

endpackage

// ### core/odc_reg_cell.sv
// Purpose: One byte-wide configuration register with its own reset value.
// Assumes: Write strobe is synchronous and one cycle long.
// Notes:   Every bit is stored, reserved ones included, so reads return what was written.
`timescale 1ns/10ps

module odc_reg_cell #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       write_en,
   input  wire logic [7:0] wdata,
   output logic [7:0]      value
);

   typedef struct packed {
      logic [7:0] value;
   } odc_cell_state_t;

   odc_cell_state_t state;
   odc_cell_state_t next_state;

   // A write replaces the whole byte.
   always_comb begin
      next_state = state;
      if (write_en) begin
         next_state.value = wdata;
      end
   end

   // Synchronous reset loads the documented default.
   always_ff @(posedge clock) begin
      if (reset) begin
         state.value <= RESET_VALUE;
      end else begin
         state <= next_state;
      end
   end

   assign value = state.value;

endmodule // odc_reg_cell

// ### core/output_driver_control_regs.sv
// Purpose: Driver control register slice of a serial video reclocker.
// Assumes: Register port and neighbouring-register inputs are synchronous to clock.
// Notes:   Outputs change two edges after the write that causes them.
//
// How it works
// - common-mode field picks 0.8, 1.0, 1.2 V
// - bit 4 powers down primary driver
// - bit 3 powers down secondary driver
// - bit 2 selects SD eye monitor mode
// - bit 1 adds long-trace equalizer boost
// - bit 0 inverts both outputs' polarity
// - bypass bit skips reclocking the data
// - mute bit low forces both outputs
// - override set makes mute bit ignored
// - clock bit puts serial clock on secondary
// - override picks sources from selection field
// - muted outputs hold mute-state logic level
`timescale 1ns/10ps
`include "odc_defs.svh"

module output_driver_control_regs (
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire odc_pkg::odc_cfg_req_t    cfg_req,
   output logic [7:0]                    cfg_rdata,
   output logic                          cfg_rvalid,
   input  wire logic                     output_select_override,
   input  wire logic [1:0]               primary_out_source_sel,
   input  wire logic [1:0]               secondary_out_source_sel,
   input  wire logic                     mute_state,
   output odc_pkg::odc_driver_cfg_t      driver_cfg,
   output odc_pkg::odc_path_t            out_path
);

   typedef struct packed {
      odc_pkg::odc_driver_cfg_t cfg;
      odc_pkg::odc_path_t       path;
      logic [7:0]               rdata;
      logic                     rvalid;
   } odc_top_state_t;

   odc_top_state_t     state;
   odc_top_state_t     next_state;
   logic [7:0]         reg_value [`ODC_REG_COUNT];
   logic [7:0]         level_reg;
   logic [7:0]         path_reg;
   odc_pkg::odc_path_t path_now;

   // One storage cell per mapped address; the reserved ones carry no function.
   for (genvar i = 0; i < `ODC_REG_COUNT; i++) begin : g_cell
      odc_reg_cell #(
         .RESET_VALUE (odc_pkg::odc_reset_value(i))
      ) u_cell (
         .clock    (clock),
         .reset    (reset),
         .write_en (cfg_req.write && (cfg_req.addr == (`ODC_FIRST_ADDR + 8'(i)))),
         .wdata    (cfg_req.wdata),
         .value    (reg_value[i])
      );
   end

   assign level_reg = reg_value[`ODC_IDX_CTRL1];
   assign path_reg  = reg_value[`ODC_IDX_CTRL2];

   // Source selection for both outputs.
   odc_path_select u_path (
      .override      (output_select_override),
      .path_reg      (path_reg),
      .primary_sel   (primary_out_source_sel),
      .secondary_sel (secondary_out_source_sel),
      .mute_state    (mute_state),
      .path          (path_now)
   );

   // Decode stored fields and answer reads; unmapped reads return zero.
   always_comb begin
      next_state                     = state;
      next_state.cfg.common_mode     = odc_pkg::odc_vos_decode(
                                          level_reg[`ODC_C1_VOS_HI:`ODC_C1_VOS_LO]);
      next_state.cfg.primary_pd      = level_reg[`ODC_C1_PD_PRI];
      next_state.cfg.secondary_pd    = level_reg[`ODC_C1_PD_SEC];
      next_state.cfg.eye_sd          = level_reg[`ODC_C1_EYE_SD];
      next_state.cfg.eq_boost        = level_reg[`ODC_C1_EQ_BOOST];
      next_state.cfg.invert          = level_reg[`ODC_C1_INVERT];
      next_state.cfg.primary_swing   = path_reg[`ODC_C2_SW_PRI_HI:`ODC_C2_SW_PRI_LO];
      next_state.cfg.secondary_swing = path_reg[`ODC_C2_SW_SEC_HI:`ODC_C2_SW_SEC_LO];
      next_state.path                = path_now;
      next_state.rvalid              = cfg_req.read;
      if (cfg_req.read) begin
         next_state.rdata = `ODC_UNMAPPED_DATA;
         for (int k = 0; k < `ODC_REG_COUNT; k++) begin
            if (cfg_req.addr == (`ODC_FIRST_ADDR + 8'(k))) begin
               next_state.rdata = reg_value[k];
            end
         end
      end
   end

   // Registering the decode keeps every output straight from a flip-flop.
   always_ff @(posedge clock) begin
      if (reset) begin
         state.cfg.common_mode     <= odc_pkg::ODC_VOS_1P2;
         state.cfg.primary_pd      <= 1'b0;
         state.cfg.secondary_pd    <= 1'b0;
         state.cfg.eye_sd          <= 1'b0;
         state.cfg.eq_boost        <= 1'b0;
         state.cfg.invert          <= 1'b0;
         state.cfg.primary_swing   <= 2'h3;
         state.cfg.secondary_swing <= 2'h3;
         state.path.primary_src    <= odc_pkg::ODC_SRC_RECLOCKED;
         state.path.secondary_src  <= odc_pkg::ODC_SRC_RECLOCKED;
         state.path.forced_level   <= 1'b0;
         state.rdata               <= 8'h00;
         state.rvalid              <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign driver_cfg = state.cfg;
   assign out_path   = state.path;
   assign cfg_rdata  = state.rdata;
   assign cfg_rvalid = state.rvalid;

   // Checks on the registered outputs against the stored fields.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence s_level_write;
      cfg_req.write && (cfg_req.addr == `ODC_ADDR_CTRL1);
   endsequence

   sequence s_path_write;
      cfg_req.write && (cfg_req.addr == `ODC_ADDR_CTRL2);
   endsequence

   sequence s_normal_mode;
      !output_select_override && path_reg[`ODC_C2_MUTE_N];
   endsequence

   // Reset is sampled here, so the edge that releases it starts no check.
   sequence s_running;
      !reset;
   endsequence

   sequence s_read_level;
      cfg_req.read && (cfg_req.addr == `ODC_ADDR_CTRL1);
   endsequence

   sequence s_read_unmapped;
      cfg_req.read && ((cfg_req.addr < `ODC_FIRST_ADDR) || (cfg_req.addr > `ODC_ADDR_CTRL2));
   endsequence

   sequence s_data_on_secondary;
      s_normal_mode ##0 !path_reg[`ODC_C2_CLOCK_SEC];
   endsequence

   a_vos_level_map: assert property (s_level_write |-> ##2
      driver_cfg.common_mode == odc_pkg::odc_vos_decode($past(cfg_req.wdata[7:6], 2)))
      else $error("common-mode level does not follow written field");

   a_primary_pd_bit: assert property (s_level_write |-> ##2
      driver_cfg.primary_pd == $past(cfg_req.wdata[`ODC_C1_PD_PRI], 2))
      else $error("primary power-down does not follow written bit");

   a_secondary_pd_bit: assert property (
      driver_cfg.secondary_pd == $past(level_reg[`ODC_C1_PD_SEC]))
      else $error("secondary power-down does not follow stored bit");

   a_eye_sd_mode: assert property (
      $changed(level_reg[`ODC_C1_EYE_SD]) |=> $changed(driver_cfg.eye_sd))
      else $error("eye monitor mode missed a change");

   a_eq_boost_bit: assert property (
      driver_cfg.eq_boost == $past(level_reg[`ODC_C1_EQ_BOOST]))
      else $error("equalizer boost does not follow stored bit");

   a_invert_write: assert property (s_level_write |-> ##2
      driver_cfg.invert == $past(cfg_req.wdata[`ODC_C1_INVERT], 2))
      else $error("polarity invert does not follow written bit");

   a_primary_swing: assert property (s_path_write |-> ##2
      driver_cfg.primary_swing == $past(cfg_req.wdata[7:6], 2))
      else $error("primary swing does not follow written field");

   a_secondary_swing: assert property (s_path_write |-> ##2
      driver_cfg.secondary_swing == $past(cfg_req.wdata[5:4], 2))
      else $error("secondary swing does not follow written field");

   a_bypass_path: assert property (s_normal_mode |=>
      out_path.primary_src == ($past(path_reg[`ODC_C2_BYPASS]) ? odc_pkg::ODC_SRC_BYPASSED
                                                             : odc_pkg::ODC_SRC_RECLOCKED))
      else $error("bypass bit did not steer primary output");

   a_mute_forces: assert property (
      (!output_select_override && !path_reg[`ODC_C2_MUTE_N]) |=>
      (out_path.primary_src == odc_pkg::ODC_SRC_FORCED) &&
      (out_path.secondary_src == odc_pkg::ODC_SRC_FORCED))
      else $error("mute did not force both outputs");

   a_mute_ignored: assert property (
      (output_select_override && (primary_out_source_sel != `ODC_SEL_FORCED)) |=>
      out_path.primary_src != odc_pkg::ODC_SRC_FORCED)
      else $error("mute acted while override was set");

   a_clock_secondary: assert property (s_normal_mode ##0 path_reg[`ODC_C2_CLOCK_SEC] |=>
      out_path.secondary_src == odc_pkg::ODC_SRC_CLOCK)
      else $error("clock not routed to secondary output");

   a_override_select: assert property (s_running ##0 output_select_override |=>
      (out_path.primary_src == odc_pkg::odc_sel_decode($past(primary_out_source_sel))) &&
      (out_path.secondary_src == odc_pkg::odc_sel_decode($past(secondary_out_source_sel))))
      else $error("override selection not applied");

   a_forced_level: assert property (s_running ##0 $changed(mute_state) |=>
      out_path.forced_level == $past(mute_state))
      else $error("forced level does not follow mute state");

   a_read_answer: assert property (cfg_req.read && (cfg_req.addr == `ODC_ADDR_CTRL2) |=>
      cfg_rvalid && (cfg_rdata == $past(path_reg)))
      else $error("read of path register answered wrongly");

   a_read_once: assert property (!cfg_req.read |=> !cfg_rvalid)
      else $error("read valid without a read");

   // Second form of the field checks: common-mode, primary power-down, invert and both swings follow
   // the stored byte one edge later, every cycle; secondary power-down, eye mode and boost follow a write.
   a_vos_follow: assert property (
      driver_cfg.common_mode ==
      odc_pkg::odc_vos_decode($past(level_reg[`ODC_C1_VOS_HI:`ODC_C1_VOS_LO])))
      else $error("common-mode level does not follow stored field");

   a_primary_pd_follow: assert property (
      driver_cfg.primary_pd == $past(level_reg[`ODC_C1_PD_PRI]))
      else $error("primary power-down does not follow stored bit");

   a_secondary_pd_write: assert property (s_level_write |-> ##2
      driver_cfg.secondary_pd == $past(cfg_req.wdata[`ODC_C1_PD_SEC], 2))
      else $error("secondary power-down does not follow written bit");

   a_eye_sd_write: assert property (s_level_write |-> ##2
      driver_cfg.eye_sd == $past(cfg_req.wdata[`ODC_C1_EYE_SD], 2))
      else $error("eye monitor mode does not follow written bit");

   a_eq_boost_write: assert property (s_level_write |-> ##2
      driver_cfg.eq_boost == $past(cfg_req.wdata[`ODC_C1_EQ_BOOST], 2))
      else $error("equalizer boost does not follow written bit");

   a_invert_follow: assert property (
      driver_cfg.invert == $past(level_reg[`ODC_C1_INVERT]))
      else $error("polarity invert does not follow stored bit");

   a_primary_swing_follow: assert property (
      driver_cfg.primary_swing == $past(path_reg[`ODC_C2_SW_PRI_HI:`ODC_C2_SW_PRI_LO]))
      else $error("primary swing does not follow stored field");

   a_secondary_swing_follow: assert property (
      driver_cfg.secondary_swing == $past(path_reg[`ODC_C2_SW_SEC_HI:`ODC_C2_SW_SEC_LO]))
      else $error("secondary swing does not follow stored field");

   a_bypass_secondary: assert property (
      s_data_on_secondary ##0 path_reg[`ODC_C2_BYPASS] |=>
      out_path.secondary_src == odc_pkg::ODC_SRC_BYPASSED)
      else $error("bypass bit did not steer secondary output");

   a_secondary_data: assert property (s_data_on_secondary |=>
      out_path.secondary_src == out_path.primary_src)
      else $error("secondary output does not carry data");

   a_secondary_unmuted: assert property (s_running ##0 (output_select_override &&
      (secondary_out_source_sel != `ODC_SEL_FORCED)) |=>
      out_path.secondary_src != odc_pkg::ODC_SRC_FORCED)
      else $error("mute acted on secondary output while override was set");

   a_forced_level_follow: assert property (s_running |=>
      out_path.forced_level == $past(mute_state))
      else $error("forced level does not hold the mute state");

   // A write stores the whole byte, reserved bits included, one edge later.
   a_level_store: assert property (s_level_write |=>
      level_reg == $past(cfg_req.wdata))
      else $error("level register did not store the written byte");

   a_path_store: assert property (s_path_write |=>
      path_reg == $past(cfg_req.wdata))
      else $error("path register did not store the written byte");

   a_read_level: assert property (s_read_level |=>
      cfg_rvalid && (cfg_rdata == $past(level_reg)))
      else $error("read of level register answered wrongly");

   // Addresses outside the slice still answer, with zero, so the host never waits.
   a_read_unmapped: assert property (s_read_unmapped |=>
      cfg_rvalid && (cfg_rdata == `ODC_UNMAPPED_DATA))
      else $error("read of unmapped address answered wrongly");

   // Read data stands until the next read.
   a_rdata_hold: assert property (s_running ##0 !cfg_req.read |=> $stable(cfg_rdata))
      else $error("read data changed without a read");

endmodule // output_driver_control_regs
